// ### acq_capture.sv
`timescale 1ns/1ps

module acq_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       reset,
	// fill side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	// drain side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];
	assign level     = cnt_q;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module acq_capture (
	// clock and reset
	input  wire logic                                       clock,
	input  wire logic                                       reset,
	// apb slave
	input  wire logic                                       psel,
	input  wire logic                                       penable,
	input  wire logic                                       pwrite,
	input  wire logic [7:0]                                 paddr,
	input  wire logic [31:0]                                pwdata,
	output logic [31:0]                                     prdata,
	output logic                                            pready,
	output logic                                            pslverr,
	// probe amplitudes, pod 0 in channels 0..16, dual channel last of each pod
	input  wire logic [acq_pkg::CHANNELS-1:0][acq_pkg::AMP_W-1:0] amp_in,
	// clock distribution
	input  wire logic [acq_pkg::STATE_CLKS-1:0]             state_clk_in,
	output logic [acq_pkg::STATE_CLKS-1:0]                  state_clk_drive,
	input  wire logic                                       sync_phase_in,
	output logic [3:0]                                      phase_out,
	input  wire logic                                       div_clk_in,
	output logic                                            div_clk_out,
	// comparator side
	output logic [acq_pkg::PODS-1:0][acq_pkg::AMP_W-1:0]    threshold_out,
	output logic                                            test_bit_out
);
	localparam int RAW_W = acq_pkg::CHANNELS * acq_pkg::AMP_W + acq_pkg::STATE_CLKS + 2;
	localparam int CH    = acq_pkg::CHANNELS;

	acq_pkg::acq_state_t state_q;
	acq_pkg::mode_t      mode_q;
	acq_pkg::clksel_t    clksel_q;
	logic [RAW_W-1:0]    sync1_q;
	logic [RAW_W-1:0]    sync2_q;
	logic [CH-1:0][acq_pkg::AMP_W-1:0] amp_s;
	logic [acq_pkg::PODS-1:0][acq_pkg::AMP_W-1:0] thr_q;
	logic [acq_pkg::STATE_CLKS-1:0] sclk_s;
	logic                phase_s;
	logic                divin_s;
	logic [acq_pkg::STATE_CLKS-1:0] sclk_prev_q;
	logic                phase_prev_q;
	logic                divin_prev_q;
	logic [7:0]          div_q;
	logic [7:0]          div_cnt_q;
	logic [CH-1:0]       pat_q;
	logic [7:0]          test_pat_q;
	logic [2:0]          test_idx_q;
	logic                test_bit_q;
	logic [CH-1:0]       cmp;
	logic [CH-1:0]       hist_q [acq_pkg::TAPS+1];
	logic [3:0]          tap_q;
	logic [2:0]          win_q;
	logic                unstable_q;
	logic                state_rise;
	logic                phase_rise;
	logic                div_rise;
	logic                tick;
	logic                tap_change;
	logic [CH-1:0]       sample;
	logic                push;
	logic                fifo_ready;
	logic                fifo_valid;
	logic [CH-1:0]       fifo_data;
	logic [3:0]          fifo_level;
	logic                pop;
	logic                overrun_q;
	logic                test_fail_q;
	logic [31:0]         events_q;
	logic [31:0]         prdata_q;
	logic                pslverr_q;
	logic                wr_en;
	logic                run_cmd;
	logic                stop_cmd;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a <= acq_pkg::ADDR_TEST) && (a[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clock) begin
		sync1_q <= {amp_in, state_clk_in, sync_phase_in, div_clk_in};
		sync2_q <= sync1_q;
	end

	assign {amp_s, sclk_s, phase_s, divin_s} = sync2_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			sclk_prev_q  <= '0;
			phase_prev_q <= 1'b0;
			divin_prev_q <= 1'b0;
		end else begin
			sclk_prev_q  <= sclk_s;
			phase_prev_q <= phase_s;
			divin_prev_q <= divin_s;
		end
	end

	// own sample clock from the six shared lines or the timing sources
	assign state_rise = sclk_s[clksel_q.line] && !sclk_prev_q[clksel_q.line];
	assign phase_rise = phase_s && !phase_prev_q;
	assign div_rise   = divin_s && !divin_prev_q;
	assign tick = !mode_q.timing ? state_rise : ((div_q == 8'h00) ? phase_rise : div_rise);

	////////////////////////////////////////////////////////////////////////////////
	// comparators and delay taps
	assign threshold_out = thr_q;
	generate
		for (genvar c = 0; c < CH; c++) begin : g_cmp
			assign cmp[c] = mode_q.test_en ? test_bit_q
				: (amp_s[c] >= thr_q[c / acq_pkg::POD_CH]);
		end
		for (genvar t = 1; t <= acq_pkg::TAPS; t++) begin : g_tap
			always_ff @(posedge clock) begin
				hist_q[t] <= hist_q[t-1];
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		hist_q[0] <= cmp;
	end

	// dual channels are dropped from the word only while they clock the state analyzer
	always_comb begin
		sample = hist_q[tap_q];
		for (int p = 0; p < acq_pkg::PODS; p++) begin
			if (!mode_q.timing && clksel_q.dual_clk[p]) begin
				sample[p*acq_pkg::POD_CH + acq_pkg::POD_CH - 1] = 1'b0;
			end
		end
	end

	assign tap_change = hist_q[tap_q] != hist_q[5'({1'b0, tap_q} + 5'h01)];

	////////////////////////////////////////////////////////////////////////////////
	// test pattern, phase generator and divider
	always_ff @(posedge clock) begin
		if (reset) begin
			test_idx_q <= '0;
			test_bit_q <= 1'b0;
		end else if (tick) begin
			test_idx_q <= test_idx_q + 3'h1;
			test_bit_q <= test_pat_q[test_idx_q];
		end
	end

	assign test_bit_out = test_bit_q;

	always_ff @(posedge clock) begin
		if (reset || !mode_q.timing) begin
			phase_out <= 4'h0;
		end else if (phase_out == 4'h0) begin
			phase_out <= 4'h1;
		end else begin
			phase_out <= {phase_out[2:0], phase_out[3]};
		end
	end

	always_ff @(posedge clock) begin
		if (reset || !mode_q.div_master || !mode_q.timing || div_q == 8'h00) begin
			div_cnt_q   <= '0;
			div_clk_out <= 1'b0;
		end else if (phase_rise) begin
			if (div_cnt_q >= div_q - 8'h01) begin
				div_cnt_q   <= '0;
				div_clk_out <= !div_clk_out;
			end else begin
				div_cnt_q <= div_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_clk_drive <= '0;
		end else begin
			for (int l = 0; l < acq_pkg::STATE_CLKS; l++) begin
				state_clk_drive[l] <= !mode_q.timing && (3'(l) == clksel_q.line)
					&& ((clksel_q.dual_clk[0] && hist_q[0][acq_pkg::POD_CH-1])
					|| (clksel_q.dual_clk[1] && hist_q[0][CH-1]));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// run sequencing: delay optimisation then capture
	always_ff @(posedge clock) begin
		if (reset || stop_cmd) begin
			state_q    <= acq_pkg::ST_IDLE;
			tap_q      <= '0;
			win_q      <= '0;
			unstable_q <= 1'b0;
		end else if (run_cmd) begin
			state_q    <= acq_pkg::ST_OPT;
			tap_q      <= '0;
			win_q      <= '0;
			unstable_q <= 1'b0;
		end else begin
			case (state_q)
				acq_pkg::ST_IDLE: begin
					state_q <= acq_pkg::ST_IDLE;
				end
				acq_pkg::ST_OPT: begin
					if (tick) begin
						win_q      <= win_q + 3'h1;
						unstable_q <= unstable_q || tap_change;
						if (win_q == acq_pkg::OPT_WIN) begin
							win_q      <= '0;
							unstable_q <= 1'b0;
							if ((!unstable_q && !tap_change) || tap_q == 4'hf) begin
								state_q <= acq_pkg::ST_CAPT;
							end else begin
								tap_q <= tap_q + 4'h1;
							end
						end
					end
				end
				acq_pkg::ST_CAPT: begin
					state_q <= acq_pkg::ST_CAPT;
				end
				default: begin
					state_q <= acq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign push = (state_q == acq_pkg::ST_CAPT) && tick && !run_cmd;

	acq_fifo #(
		.WIDTH (CH),
		.DEPTH (acq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset     (reset || run_cmd),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (sample),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data),
		.level     (fifo_level)
	);

	// pattern events, overrun and self-test check
	always_ff @(posedge clock) begin
		if (reset || run_cmd) begin
			events_q    <= '0;
			overrun_q   <= 1'b0;
			test_fail_q <= 1'b0;
		end else if (push) begin
			if (sample == pat_q) begin
				events_q <= events_q + 32'h1;
			end
			if (!fifo_ready) begin
				overrun_q <= 1'b1;
			end
			if (mode_q.test_en && hist_q[tap_q] != {CH{hist_q[tap_q][0]}}) begin
				test_fail_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb register file
	assign wr_en    = psel && penable && pwrite;
	assign run_cmd  = wr_en && paddr == acq_pkg::ADDR_CTRL && pwdata[acq_pkg::CTRL_RUN];
	assign stop_cmd = wr_en && paddr == acq_pkg::ADDR_CTRL && pwdata[acq_pkg::CTRL_STOP];
	assign pop      = psel && penable && !pwrite && paddr == acq_pkg::ADDR_DHI && fifo_valid;
	assign pready   = 1'b1;
	assign prdata   = prdata_q;
	assign pslverr  = pslverr_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			mode_q     <= '0;
			thr_q      <= {acq_pkg::THRESH_RST, acq_pkg::THRESH_RST};
			clksel_q   <= '{dual_clk: 2'h0, line: acq_pkg::LINE_RST};
			div_q      <= acq_pkg::DIV_RST;
			pat_q      <= '0;
			test_pat_q <= acq_pkg::TEST_RST;
		end else if (wr_en) begin
			case (paddr)
				acq_pkg::ADDR_CTRL:   mode_q <= pwdata[acq_pkg::CTRL_MODE_L +: 3];
				acq_pkg::ADDR_THRESH: thr_q  <= pwdata[7:0];
				acq_pkg::ADDR_CLKSEL: begin
					if (pwdata[2:0] < 3'(acq_pkg::STATE_CLKS)) begin
						clksel_q <= pwdata[4:0];
					end
				end
				acq_pkg::ADDR_DIV: begin
					div_q           <= pwdata[7:0];
					pat_q[CH-1:32]  <= pwdata[acq_pkg::DIV_PATHI +: 2];
				end
				acq_pkg::ADDR_PAT:  pat_q[31:0] <= pwdata;
				acq_pkg::ADDR_TEST: test_pat_q  <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// read data is latched in the setup cycle and shown in the access cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= !addr_known(paddr);
			case (paddr)
				acq_pkg::ADDR_CTRL:   prdata_q <= {27'h0, mode_q, 2'h0};
				acq_pkg::ADDR_STATUS: prdata_q <= {19'h0, fifo_valid, test_fail_q, overrun_q,
					fifo_level, tap_q, state_q};
				acq_pkg::ADDR_THRESH: prdata_q <= {24'h0, thr_q};
				acq_pkg::ADDR_CLKSEL: prdata_q <= {27'h0, clksel_q};
				acq_pkg::ADDR_DIV:    prdata_q <= {22'h0, pat_q[CH-1:32], div_q};
				acq_pkg::ADDR_PAT:    prdata_q <= pat_q[31:0];
				acq_pkg::ADDR_DLO:    prdata_q <= fifo_data[31:0];
				acq_pkg::ADDR_DHI:    prdata_q <= {29'h0, fifo_valid, fifo_data[CH-1:32]};
				acq_pkg::ADDR_EVENTS: prdata_q <= events_q;
				acq_pkg::ADDR_TEST:   prdata_q <= {24'h0, test_pat_q};
				default:              prdata_q <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_run_starts_opt: assert property (run_cmd && !stop_cmd
		|=> state_q == acq_pkg::ST_OPT && tap_q == 4'h0)
		else $error("run did not start delay optimisation");
	a_capt_after_opt: assert property ($rose(state_q == acq_pkg::ST_CAPT)
		|-> $past(state_q) == acq_pkg::ST_OPT && $past(win_q) == acq_pkg::OPT_WIN)
		else $error("capture began without a finished optimisation window");
	a_dual_clk_masked: assert property (push && !mode_q.timing && clksel_q.dual_clk[1]
		|-> !sample[CH-1])
		else $error("dual channel stored while used as clock");
	a_test_bit_copy: assert property (mode_q.test_en && $past(mode_q.test_en)
		|-> hist_q[0] == {CH{$past(test_bit_q)}})
		else $error("test bit not copied to every channel");
	a_fast_tick_push: assert property (mode_q.timing && div_q == 8'h00 && phase_rise
		&& state_q == acq_pkg::ST_CAPT && fifo_ready && !run_cmd |=> fifo_level != 4'h0)
		else $error("fast timing edge did not store a sample");
	a_div_out_period: assert property ($changed(div_clk_out) && $past(mode_q.div_master)
		&& $past(mode_q.timing) && $past(div_q) != 8'h00
		|-> $past(div_cnt_q) >= $past(div_q) - 8'h01)
		else $error("divided clock toggled early");
	a_phase_rotates: assert property (mode_q.timing && phase_out != 4'h0
		|=> phase_out == {$past(phase_out[2:0]), $past(phase_out[3])} || !mode_q.timing)
		else $error("phase signal did not rotate");
	a_pod_threshold: assert property (!mode_q.test_en
		|=> hist_q[0][CH-1] == ($past(amp_s[CH-1]) >= $past(thr_q[1])))
		else $error("pod one dual channel compared against wrong threshold");
	a_clk_line_legal: assert property (clksel_q.line < 3'(acq_pkg::STATE_CLKS))
		else $error("state clock line out of range");
	a_test_fail_flag: assert property (push && mode_q.test_en && !run_cmd
		&& hist_q[tap_q] != {CH{hist_q[tap_q][0]}} |=> test_fail_q)
		else $error("self-test mismatch not flagged");

	c_opt_done: cover property (state_q == acq_pkg::ST_OPT ##1 state_q == acq_pkg::ST_CAPT);
	c_fifo_full: cover property (state_q == acq_pkg::ST_CAPT && !fifo_ready);
	c_slow_timing: cover property (mode_q.timing && div_q != 8'h00 && push);
	c_test_run: cover property (mode_q.test_en && push);
endmodule

// ### acq_pkg.sv
package acq_pkg;
	// channel geometry
	localparam int PODS        = 2;
	localparam int POD_CH      = 17;
	localparam int CHANNELS    = 34;
	localparam int CMP_CH      = 9;
	localparam int AMP_W       = 4;
	localparam int STATE_CLKS  = 6;
	localparam int TAPS        = 16;
	localparam int FIFO_DEPTH  = 8;
	localparam logic [2:0] OPT_WIN = 3'h7;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_THRESH = 8'h08;
	localparam logic [7:0] ADDR_CLKSEL = 8'h0c;
	localparam logic [7:0] ADDR_DIV    = 8'h10;
	localparam logic [7:0] ADDR_PAT    = 8'h14;
	localparam logic [7:0] ADDR_DLO    = 8'h18;
	localparam logic [7:0] ADDR_DHI    = 8'h1c;
	localparam logic [7:0] ADDR_EVENTS = 8'h20;
	localparam logic [7:0] ADDR_TEST   = 8'h24;
	// control, clock select and divider register field positions
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_STOP   = 1;
	localparam int CTRL_MODE_L = 2;
	localparam int CLKSEL_DUAL = 3;
	localparam int DIV_PATHI   = 8;
	// reset values
	localparam logic [3:0] THRESH_RST = 4'h8;
	localparam logic [7:0] DIV_RST    = 8'h00;
	localparam logic [7:0] TEST_RST   = 8'ha5;
	localparam logic [2:0] LINE_RST   = 3'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_OPT  = 2'b01,
		ST_CAPT = 2'b10
	} acq_state_t;

	typedef struct packed {
		logic test_en;
		logic div_master;
		logic timing;
	} mode_t;

	typedef struct packed {
		logic [1:0] dual_clk;
		logic [2:0] line;
	} clksel_t;
endpackage

// ### probe_model.sv
`timescale 1ns/1ps

module probe_model (
	// clock
	input  wire logic                                             clock,
	// bench control
	input  wire logic                                             tick_go,
	input  wire logic [7:0]                                       tick_mask,
	input  wire logic [acq_pkg::CHANNELS-1:0][acq_pkg::AMP_W-1:0] amp_val,
	// pod side
	output logic [acq_pkg::CHANNELS-1:0][acq_pkg::AMP_W-1:0]      amp_in,
	output logic [5:0]                                            state_clk_in,
	output logic                                                  sync_phase_in,
	output logic                                                  div_clk_in,
	output logic                                                  busy
);
	logic [2:0] cnt_q  = 3'h0;
	logic [7:0] hold_q = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// three cycles high, three low: each pulse survives the synchronisers
	always_ff @(posedge clock) begin
		if (tick_go && cnt_q == 3'h0) begin
			cnt_q  <= 3'h6;
			hold_q <= tick_mask;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	assign busy = cnt_q != 3'h0;
	assign {div_clk_in, sync_phase_in, state_clk_in} = (cnt_q > 3'h3) ? hold_q : 8'h00;
	// seventeen levels per pod, dual channel last
	assign amp_in = amp_val;
endmodule

// ### logic_acquisition_sampling_bench.sv
`timescale 1ns/1ps

module logic_acquisition_sampling_bench;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
		logic        err;
	} note_t;

	logic              clock = 1'b0;
	logic              reset = 1'b1;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
	logic [7:0]        paddr = 8'h00, tick_mask = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, rd, seed = 32'h0001437b;
	logic              pready, pslverr, er, tick_go = 1'b0, busy, dprev = 1'b0;
	logic [33:0][3:0]  amp_val = '0, amp_in;
	logic [5:0]        state_clk_in, state_clk_drive;
	logic              sync_phase_in, div_clk_in, div_clk_out, test_bit_out;
	logic [3:0]        phase_out, p0, t0, t1;
	logic [1:0][3:0]   threshold_out;
	logic [33:0]       w;
	int                mismatches = 0, tests_run = 0, n, k, tog = 0, ts;
	note_t             notes[$];
	note_t             nt;

	acq_capture u_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .amp_in(amp_in), .state_clk_in(state_clk_in),
		.state_clk_drive(state_clk_drive), .sync_phase_in(sync_phase_in),
		.phase_out(phase_out), .div_clk_in(div_clk_in), .div_clk_out(div_clk_out),
		.threshold_out(threshold_out), .test_bit_out(test_bit_out));

	probe_model u_probe (.clock(clock), .tick_go(tick_go), .tick_mask(tick_mask),
		.amp_val(amp_val), .amp_in(amp_in), .state_clk_in(state_clk_in),
		.sync_phase_in(sync_phase_in), .div_clk_in(div_clk_in), .busy(busy));

	initial begin
		forever #20 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [33:0] word_of(input logic dual_clk);
		logic [33:0] r;
		for (int c = 0; c < 34; c++) r[c] = amp_val[c] >= ((c < 17) ? t0 : t1);
		if (dual_clk) r[33] = 1'b0;
		return r;
	endfunction

	task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			mismatches++;
		end
	endtask

	task automatic check_err(input string nm, input logic exp, input logic seen);
		tests_run++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, seen);
			mismatches++;
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic chk);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		want    <= chk;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			results();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		want    <= 1'b0;
	endtask

	task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic err);
		notes.push_back('{e & m, m, err});
		apb(1'b0, a, 32'h0, 1'b1);
	endtask

	task automatic tick(input logic [7:0] m);
		@(posedge clock);
		tick_go   <= 1'b1;
		tick_mask <= m;
		@(posedge clock);
		tick_go <= 1'b0;
		k = 0;
		while (busy === 1'b1 && k < 50) begin
			@(posedge clock);
			k++;
		end
		if (k >= 50) begin
			mismatches++;
			results();
		end
		repeat (6) @(posedge clock);
	endtask

	task automatic run_to_capt(input logic [7:0] m);
		int j;
		j = 0;
		do begin
			tick(m);
			apb(1'b0, acq_pkg::ADDR_STATUS, 32'h0, 1'b0);
			j++;
		end while (rd[1:0] !== 2'b10 && j < 140);
		if (rd[1:0] !== 2'b10) begin
			mismatches++;
			results();
		end
		j = 0;
		do begin
			apb(1'b0, acq_pkg::ADDR_DHI, 32'h0, 1'b0);
			j++;
		end while (rd[2] === 1'b1 && j < 12);
	endtask

	// watcher: every noted read is compared when its access completes
	always @(posedge clock) begin
		if (want && psel && penable && pready === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check_word($sformatf("reg %h", paddr), nt.exp, prdata & nt.mask);
			check_err($sformatf("err %h", paddr), nt.err, pslverr);
		end
		if (div_clk_out !== dprev) tog <= tog + 1;
		dprev <= div_clk_out;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		rdx(acq_pkg::ADDR_STATUS, 32'h0, 32'h1fff, 1'b0);
		rdx(acq_pkg::ADDR_THRESH, 32'h88, 32'hff, 1'b0);
		rdx(acq_pkg::ADDR_DIV, 32'h0, 32'h3ff, 1'b0);
		rdx(acq_pkg::ADDR_TEST, 32'ha5, 32'hff, 1'b0);
		rdx(8'h28, 32'h0, 32'hffffffff, 1'b1);
		rdx(8'h02, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, acq_pkg::ADDR_CLKSEL, 32'h7, 1'b0);
		rdx(acq_pkg::ADDR_CLKSEL, 32'h0, 32'h1f, 1'b0);
		apb(1'b1, acq_pkg::ADDR_CLKSEL, 32'h12, 1'b0);
		rdx(acq_pkg::ADDR_CLKSEL, 32'h12, 32'h1f, 1'b0);
		seed = xs(seed);
		t0 = seed[3:0];
		t1 = seed[7:4];
		for (int c = 0; c < 34; c++) begin
			seed = xs(seed);
			amp_val[c] <= seed[3:0];
		end
		apb(1'b1, acq_pkg::ADDR_THRESH, {24'h0, t1, t0}, 1'b0);
		w = word_of(1'b1);
		apb(1'b1, acq_pkg::ADDR_PAT, w[31:0], 1'b0);
		apb(1'b1, acq_pkg::ADDR_DIV, {22'h0, w[33:32], 8'h00}, 1'b0);
		check_word("threshold", {24'h0, t1, t0}, {24'h0, threshold_out});
		apb(1'b1, acq_pkg::ADDR_CTRL, 32'h1, 1'b0);
		rdx(acq_pkg::ADDR_STATUS, 32'h1, 32'h1003, 1'b0);
		run_to_capt(8'h04);
		tick(8'h08);
		rdx(acq_pkg::ADDR_STATUS, 32'h0, 32'h1000, 1'b0);
		check_word("clock drive", {29'h0, amp_val[33] >= t1, 2'h0}, {26'h0, state_clk_drive});
		tick(8'h04);
		rdx(acq_pkg::ADDR_EVENTS, 32'h1, 32'hffffffff, 1'b0);
		rdx(acq_pkg::ADDR_DLO, w[31:0], 32'hffffffff, 1'b0);
		rdx(acq_pkg::ADDR_DHI, {29'h0, 1'b1, w[33:32]}, 32'h7, 1'b0);
		repeat (10) tick(8'h04);
		rdx(acq_pkg::ADDR_STATUS, 32'h1600, 32'h1fc0, 1'b0);
		repeat (8) begin
			rdx(acq_pkg::ADDR_DLO, w[31:0], 32'hffffffff, 1'b0);
			rdx(acq_pkg::ADDR_DHI, {29'h0, 1'b1, w[33:32]}, 32'h7, 1'b0);
		end
		rdx(acq_pkg::ADDR_DHI, 32'h0, 32'h4, 1'b0);
		apb(1'b1, acq_pkg::ADDR_DIV, 32'h0, 1'b0);
		apb(1'b1, acq_pkg::ADDR_CTRL, 32'h5, 1'b0);
		repeat (2) @(posedge clock);
		p0 = phase_out;
		check_word("phase", 32'h1, {31'h0, p0 !== 4'h0 && (p0 & (p0 - 4'h1)) === 4'h0});
		@(posedge clock);
		check_word("phase step", 32'h1, {31'h0, phase_out !== p0});
		repeat (3) @(posedge clock);
		check_word("phase period", {28'h0, p0}, {28'h0, phase_out});
		run_to_capt(8'h40);
		tick(8'h40);
		w = word_of(1'b0);
		rdx(acq_pkg::ADDR_DLO, w[31:0], 32'hffffffff, 1'b0);
		rdx(acq_pkg::ADDR_DHI, {29'h0, 1'b1, w[33:32]}, 32'h7, 1'b0);
		apb(1'b1, acq_pkg::ADDR_DIV, 32'h2, 1'b0);
		apb(1'b1, acq_pkg::ADDR_CTRL, 32'hd, 1'b0);
		ts = tog;
		repeat (8) tick(8'h40);
		check_word("div toggles", 32'h4, 32'(tog - ts));
		run_to_capt(8'h80);
		tick(8'h80);
		rdx(acq_pkg::ADDR_STATUS, 32'h1000, 32'h1000, 1'b0);
		apb(1'b1, acq_pkg::ADDR_TEST, 32'hff, 1'b0);
		apb(1'b1, acq_pkg::ADDR_CTRL, 32'h11, 1'b0);
		run_to_capt(8'h04);
		repeat (4) tick(8'h04);
		check_err("test bit", 1'b1, test_bit_out);
		rdx(acq_pkg::ADDR_STATUS, 32'h1000, 32'h1800, 1'b0);
		rdx(acq_pkg::ADDR_DLO, 32'hffffffff, 32'hffffffff, 1'b0);
		rdx(acq_pkg::ADDR_DHI, 32'h5, 32'h7, 1'b0);
		apb(1'b1, acq_pkg::ADDR_CTRL, 32'h2, 1'b0);
		rdx(acq_pkg::ADDR_STATUS, 32'h0, 32'h3, 1'b0);
		repeat (4) @(posedge clock);
		results();
	end
endmodule
